// ---- logic/tpg_defs.svh ----
// Constants for the converter output test pattern generator.
// Assumes inclusion by bare name from files that use the generator.
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TPG_ADDR_W          12
`define TPG_OFF_MODE        12'h550
`define TPG_OFF_USER_FIRST  12'h551
`define TPG_OFF_USER_LAST   12'h558
`define TPG_OFF_DDC0_EN     12'h327
`define TPG_OFF_DDC1_EN     12'h347
`define TPG_OFF_DDC2_EN     12'h367
`define TPG_OFF_FOURTH_DOWNCONVERTER_EN     12'h387

// ----------------------------------------------------------------------
// Mode and downconverter enable register fields and reset values
// ----------------------------------------------------------------------
`define TPG_SEL_HI          3
`define TPG_SEL_LO          0
`define TPG_BIT_RESEED_LONG 4
`define TPG_BIT_RESEED_SHRT 5
`define TPG_BIT_USER_SINGLE 7
`define TPG_BIT_DDC_I_EN    0
`define TPG_BIT_DDC_Q_EN    2
`define TPG_RST_BYTE        8'h00

// ----------------------------------------------------------------------
// Pattern select codes
// ----------------------------------------------------------------------
`define TPG_SEL_OFF         4'h0
`define TPG_SEL_MIDSCALE    4'h1
`define TPG_SEL_POS_FULL    4'h2
`define TPG_SEL_NEG_FULL    4'h3
`define TPG_SEL_CHECKER     4'h4
`define TPG_SEL_PN_LONG     4'h5
`define TPG_SEL_PN_SHORT    4'h6
`define TPG_SEL_TOGGLE      4'h7
`define TPG_SEL_USER        4'h8
`define TPG_SEL_RAMP        4'hf

// ----------------------------------------------------------------------
// Pattern words and seeds
// ----------------------------------------------------------------------
`define TPG_W_MIDSCALE      14'h0000
`define TPG_W_POS_FULL      14'h1fff
`define TPG_W_NEG_FULL      14'h2000
`define TPG_W_CHECK_A       14'h1555
`define TPG_W_CHECK_B       14'h2aaa
`define TPG_W_ZEROS         14'h0000
`define TPG_W_ONES          14'h3fff
`define TPG_SEED_LONG       23'h003aff
`define TPG_SEED_SHORT      9'h092
`define TPG_TAP_LONG        18
`define TPG_TAP_SHORT       5
`define TPG_USER_HI         15
`define TPG_USER_LO         2

`endif

// ---- logic/tpg_pkg.sv ----
// Types shared by the test pattern generator and its bench.
// Assumes tpg_defs.svh sits on the include path.
package tpg_pkg;

  // ----------------------------------------------------------------------
  // Sample carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [13:0] a;
    logic [13:0] b;
  } tpg_conv_t;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } tpg_iq_t;

  typedef struct packed {
    tpg_conv_t          conv;
    tpg_iq_t [3:0]      ddc;
  } tpg_frame_t;

  // Single-shot user sequence progress
  typedef enum logic [0:0] {
    TPG_US_RUN,
    TPG_US_DONE
  } tpg_user_st_t;

endpackage

// ---- logic/tpg_buf2.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module tpg_buf2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] mem [2];
  logic [1:0]       count;
  logic             wptr;
  logic             rptr;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rptr];

  // Storage; entries are flops so the drained word is registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem[0] <= '0;
      mem[1] <= '0;
    end else if (push) begin
      mem[wptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr  <= 1'b0;
      rptr  <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wptr <= ~wptr;
      end
      if (pop) begin
        rptr <= ~rptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// ---- logic/tpg_gen.sv ----
// Converter output test pattern generator with register port.
// Assumes samples arrive synchronous to clk (the encode clock); a stopped
// clock simply freezes every generator.
`timescale 1ns/100ps
`include "tpg_defs.svh"

// Overview of operation
// - Any selected pattern replaces converter samples and passes the formatting stage.
// - Only fixed and ramp patterns are formatted; others pass unchanged.
// - Setting either reseed bit restarts pseudorandom generators from their seeds.
// - Patterns ignore analog input and advance only on encode clock samples.
// - Four-bit select field picks the pattern; zero means off, the default.
// - Downconverter I words carry channel A pattern, Q words channel B.
// - Fourth downconverter: I takes channel A when bit 0 set; Q never patterned.
// - Checkerboard alternates two fixed words, first word first, one per sample.
// - Long mode uses a 23-stage generator from its seed.
// - Short mode uses a 9-stage generator from its seed.
// - Word toggle alternates all zeros and all ones, zeros first.
// - Repeat user mode cycles bits 15..2 of four user words.
// - Single user mode sends four user words once, then zeros.
module tpg_gen
  import tpg_pkg::*;
#(
  parameter int NCH  = 2,
  parameter int NDDC = 4
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // Register port
  input  wire logic                   reg_wr,
  input  wire logic [`TPG_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic [7:0]                  reg_rdata,
  // Static configuration
  input  wire logic                   ddc_mode,
  input  wire logic                   offset_binary,
  // Converter and downconverter samples in
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire tpg_frame_t             in_frame,
  // Samples toward the serial link
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output tpg_frame_t                  out_frame,
  // Pattern active indication
  output logic                        test_active
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  mode_reg;
  logic [7:0]  user_byte [8];
  logic [7:0]  ddc_en    [NDDC];
  logic [3:0]  sel;
  logic        fire;
  tpg_frame_t  next_frame;
  logic [13:0] pat [NCH];

  assign sel         = mode_reg[`TPG_SEL_HI:`TPG_SEL_LO];
  assign test_active = (sel != `TPG_SEL_OFF);
  assign fire        = in_valid & in_ready;

  // Mode register; plain write, no self-clearing bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= `TPG_RST_BYTE;
    end else if (reg_wr && reg_addr == `TPG_OFF_MODE) begin
      mode_reg <= reg_wdata;
    end
  end

  // User pattern bytes and downconverter enables
  genvar gu;
  generate
    for (gu = 0; gu < 8; gu++) begin : g_user
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          user_byte[gu] <= `TPG_RST_BYTE;
        end else if (reg_wr && reg_addr == `TPG_OFF_USER_FIRST + 12'(gu)) begin
          user_byte[gu] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Per-downconverter enable register, one offset each
  function automatic logic [11:0] ddc_off(input int d);
    logic [11:0] r;
    case (d)
      0:       r = `TPG_OFF_DDC0_EN;
      1:       r = `TPG_OFF_DDC1_EN;
      2:       r = `TPG_OFF_DDC2_EN;
      default: r = `TPG_OFF_FOURTH_DOWNCONVERTER_EN;
    endcase
    return r;
  endfunction

  genvar gd;
  generate
    for (gd = 0; gd < NDDC; gd++) begin : g_den
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ddc_en[gd] <= `TPG_RST_BYTE;
        end else if (reg_wr && reg_addr == ddc_off(gd)) begin
          ddc_en[gd] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Read data is registered; unmapped offsets read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `TPG_RST_BYTE;
    end else begin
      reg_rdata <= `TPG_RST_BYTE;
      if (reg_addr == `TPG_OFF_MODE) begin
        reg_rdata <= mode_reg;
      end
      if (reg_addr >= `TPG_OFF_USER_FIRST && reg_addr <= `TPG_OFF_USER_LAST) begin
        reg_rdata <= user_byte[3'(reg_addr - `TPG_OFF_USER_FIRST)];
      end
      for (int d = 0; d < NDDC; d++) begin
        if (reg_addr == ddc_off(d)) begin
          reg_rdata <= ddc_en[d];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pseudorandom step functions, fourteen shifts per sample
  // ----------------------------------------------------------------------
  function automatic logic [22:0] step_long(input logic [22:0] s);
    logic [22:0] r;
    r = s;
    for (int k = 0; k < 14; k++) begin
      r = {r[21:0], r[22] ^ r[`TPG_TAP_LONG-1]};
    end
    return r;
  endfunction

  function automatic logic [8:0] step_short(input logic [8:0] s);
    logic [8:0] r;
    r = s;
    for (int k = 0; k < 14; k++) begin
      r = {r[7:0], r[8] ^ r[`TPG_TAP_SHORT-1]};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Per-channel generators
  // ----------------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_ch
      logic [22:0]  pn_long;
      logic [8:0]   pn_short;
      logic [13:0]  ramp;
      logic         phase;
      logic [1:0]   uidx;
      tpg_user_st_t ust;
      logic [13:0]  uword;
      logic [15:0]  uraw;
      logic [22:0]  next_pn_long;
      logic [8:0]   next_pn_short;
      logic [13:0]  raw;

      // User word is the byte pair; the low two bits are dropped
      assign uraw          = {user_byte[{uidx, 1'b1}], user_byte[{uidx, 1'b0}]};
      assign uword         = uraw[`TPG_USER_HI:`TPG_USER_LO];
      assign next_pn_long  = step_long(pn_long);
      assign next_pn_short = step_short(pn_short);

      // Seeds reload while a reseed bit is set, so the next word restarts
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pn_long  <= `TPG_SEED_LONG;
          pn_short <= `TPG_SEED_SHORT;
        end else begin
          if (mode_reg[`TPG_BIT_RESEED_LONG] || mode_reg[`TPG_BIT_RESEED_SHRT]) begin
            pn_long  <= `TPG_SEED_LONG;
            pn_short <= `TPG_SEED_SHORT;
          end else if (fire) begin
            pn_long  <= next_pn_long;
            pn_short <= next_pn_short;
          end
        end
      end

      // Toggle phase and user index restart whenever patterns are off; the ramp keeps its count
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ramp  <= '0;
          phase <= 1'b0;
          uidx  <= 2'h0;
          ust   <= TPG_US_RUN;
        end else if (!test_active) begin
          phase <= 1'b0;
          uidx  <= 2'h0;
          ust   <= TPG_US_RUN;
        end else if (fire) begin
          ramp  <= ramp + 14'h0001;
          phase <= ~phase;
          uidx  <= uidx + 2'h1;
          case (ust)
            TPG_US_RUN: begin
              if (uidx == 2'h3 && mode_reg[`TPG_BIT_USER_SINGLE]) begin
                ust <= TPG_US_DONE;
              end
            end
            TPG_US_DONE: ust <= TPG_US_DONE;
            default:     ust <= TPG_US_RUN;
          endcase
        end
      end

      // Word selection; analog samples never enter this path
      always_comb begin
        raw = `TPG_W_ZEROS;
        case (sel)
          `TPG_SEL_MIDSCALE: raw = `TPG_W_MIDSCALE;
          `TPG_SEL_POS_FULL: raw = `TPG_W_POS_FULL;
          `TPG_SEL_NEG_FULL: raw = `TPG_W_NEG_FULL;
          `TPG_SEL_CHECKER:  raw = phase ? `TPG_W_CHECK_B : `TPG_W_CHECK_A;
          `TPG_SEL_PN_LONG:  raw = next_pn_long[13:0];
          `TPG_SEL_PN_SHORT: raw = next_pn_short[13:0];
          `TPG_SEL_TOGGLE:   raw = phase ? `TPG_W_ONES : `TPG_W_ZEROS;
          `TPG_SEL_USER:     raw = (ust == TPG_US_DONE) ? `TPG_W_ZEROS : uword;
          `TPG_SEL_RAMP:     raw = ramp;
          default:           raw = `TPG_W_ZEROS;
        endcase
      end

      // Formatting touches only fixed and ramp words; offset binary flips MSB
      always_comb begin
        pat[gc] = raw;
        if (offset_binary && (sel == `TPG_SEL_MIDSCALE || sel == `TPG_SEL_POS_FULL ||
            sel == `TPG_SEL_NEG_FULL || sel == `TPG_SEL_RAMP)) begin
          pat[gc] = {~raw[13], raw[12:0]};
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Injection into the converter and downconverter words
  // ----------------------------------------------------------------------
  always_comb begin
    next_frame = in_frame;
    // Converter path: analog result cut off, live samples pass when off
    if (test_active) begin
      next_frame.conv.a = pat[0];
      next_frame.conv.b = pat[1];
    end
    // Downconverters: I from channel A, Q from channel B, last one I only
    for (int d = 0; d < NDDC; d++) begin
      if (test_active && ddc_mode && ddc_en[d][`TPG_BIT_DDC_I_EN]) begin
        next_frame.ddc[d].i = {pat[0], 2'b00};
      end
      if (test_active && ddc_mode && ddc_en[d][`TPG_BIT_DDC_Q_EN] && d != NDDC - 1) begin
        next_frame.ddc[d].q = {pat[1], 2'b00};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output buffer; a stalled receiver holds back the source instead of
  // dropping a word, and generators only step on accepted samples
  // ----------------------------------------------------------------------
  tpg_buf2 #(
    .WIDTH ($bits(tpg_frame_t))
  ) u_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (next_frame),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_frame)
  );

endmodule

// ---- tb/tpg_gen_checker.sv ----
// Port assertions for the converter output test pattern generator.
// Assumes it is bound into tpg_gen; the select field is shadowed from writes.
`timescale 1ns/100ps
module tpg_gen_checker
  import tpg_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register port
  input wire logic        reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // Configuration
  input wire logic        ddc_mode,
  input wire logic        offset_binary,
  // Stream
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire tpg_frame_t  in_frame,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire tpg_frame_t  out_frame,
  input wire logic        test_active
);
  logic [3:0] sel_q;
  logic       take;
  logic       first;
  logic       mapped;

  // Take into an empty buffer shows up at the output one cycle later
  assign take = in_valid && in_ready;
  assign first = take && !out_valid && !ddc_mode;
  assign mapped = reg_addr == 12'h550 || (reg_addr >= 12'h551 && reg_addr <= 12'h558)
    || reg_addr == 12'h327 || reg_addr == 12'h347 || reg_addr == 12'h367
    || reg_addr == 12'h387;

  // Shadow select, so outputs can be tied to the mode without seeing inside
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sel_q <= 4'h0;
    else if (reg_wr && reg_addr == 12'h550) sel_q <= reg_wdata[3:0];
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  // ---------
  // Assertions
  // ---------
  chk_sel_active: assert property (test_active == (sel_q != 4'h0))
    else $error("test_active disagrees with select field");
  chk_mode_readback: assert property ((reg_wr && reg_addr == 12'h550) ##1
    (reg_addr == 12'h550) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mode register readback wrong");
  chk_unmapped_zero: assert property (!mapped |=> reg_rdata == 8'h00)
    else $error("unmapped offset read not zero");
  chk_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_frame))
    else $error("output dropped or changed while stalled");
  chk_full_nonempty: assert property (!in_ready |-> out_valid)
    else $error("refusing input with empty buffer");
  chk_off_pass: assert property (first && sel_q == 4'h0 |=>
    out_frame == $past(in_frame))
    else $error("samples not passed through when off");
  chk_fixed_word: assert property (first && sel_q == 4'h2 |=>
    out_frame.conv.a == {$past(offset_binary), 13'h1fff})
    else $error("positive full scale word wrong");
  chk_checker_pair: assert property (first && sel_q == 4'h4 |=>
    out_frame.conv.a == out_frame.conv.b
    && (out_frame.conv.a == 14'h1555 || out_frame.conv.a == 14'h2aaa))
    else $error("checkerboard word wrong");

  // Main scenarios
  cov_full: cover property (!in_ready);
  cov_stall: cover property (out_valid && !out_ready);
  cov_user: cover property (take && sel_q == 4'h8);
endmodule

bind tpg_gen tpg_gen_checker u_chk (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ddc_mode(ddc_mode), .offset_binary(offset_binary), .in_valid(in_valid),
  .in_ready(in_ready), .in_frame(in_frame), .out_valid(out_valid),
  .out_ready(out_ready), .out_frame(out_frame), .test_active(test_active));

// ---- tb/tpg_rx_model.sv ----
// Link receiver model: takes frames and may stall at random.
// Assumes the valid/ready stream of tpg_gen on one clock.
`timescale 1ns/100ps
module tpg_rx_model
  import tpg_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Stall control
  input wire logic       stall,
  // Stream from the generator
  input wire logic       out_valid,
  input wire tpg_frame_t out_frame,
  output logic           out_ready
);
  tpg_frame_t q [$];

  // Ready moves just after the edge; half the cycles stalled when asked
  always @(posedge clk or negedge rstn) begin
    if (!rstn) out_ready <= 1'b0;
    else out_ready <= #1 stall ? 1'($urandom % 2) : 1'b1;
  end

  // Keep every accepted frame for the bench to compare
  always @(posedge clk) begin
    if (rstn && out_valid && out_ready) q.push_back(out_frame);
  end
endmodule

// ---- tb/tb_tpg_gen.sv ----
// Bench for tpg_gen: registers, every pattern, receiver stalls.
// Assumes tpg_rx_model as far side and the bound checker.
`timescale 1ns/100ps
module tb_tpg_gen
  import tpg_pkg::*;
;
  logic        clk, rstn, reg_wr, ddc_mode, offset_binary, stall;
  logic        in_valid, in_ready, out_valid, out_ready, test_active;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [7:0]  ub [8];
  tpg_frame_t  in_frame, out_frame;
  tpg_frame_t  tx [$];
  tpg_frame_t  pn [$];
  int          bad_count, n_checks, full_seen;

  tpg_gen uut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ddc_mode(ddc_mode),
    .offset_binary(offset_binary), .in_valid(in_valid), .in_ready(in_ready),
    .in_frame(in_frame), .out_valid(out_valid), .out_ready(out_ready),
    .out_frame(out_frame), .test_active(test_active));
  tpg_rx_model rx (.clk(clk), .rstn(rstn), .stall(stall), .out_valid(out_valid),
    .out_frame(out_frame), .out_ready(out_ready));

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Tests need under 2000 cycles; 40000 leaves ample margin
  initial begin
    #200000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  // ---------
  // Tasks
  // ---------
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Strobe is dropped a full cycle before the next write may raise it
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    reg_addr = a;
    @(posedge clk);
    #1;
    chk(32'(reg_rdata), 32'(e), "register read");
  endtask
  // Send n random frames back to back, then wait for all to drain
  task automatic run(input int n);
    logic [159:0] r;
    tx.delete();
    rx.q.delete();
    in_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      r = {$urandom, $urandom, $urandom, $urandom, $urandom};
      in_frame = r[155:0];
      tx.push_back(in_frame);
      do begin
        @(negedge clk);
        full_seen += int'(!in_ready);
      end while (!in_ready);
      @(posedge clk);
      #1;
    end
    in_valid = 1'b0;
    for (int t = 0; t < 100 && rx.q.size() < n; t++) @(negedge clk);
    @(posedge clk);
    #1;
    chk(32'(rx.q.size()), 32'(n), "frame count");
  endtask
  // Expected word k after a restart of mode m
  function automatic logic [13:0] exp_w(input logic [7:0] m, input int k, input logic ob);
    logic [15:0] u;
    u = {ub[2 * (k % 4) + 1], ub[2 * (k % 4)]};
    case (m[3:0])
      4'h1: exp_w = {ob, 13'h0000};
      4'h2: exp_w = {ob, 13'h1fff};
      4'h3: exp_w = {~ob, 13'h0000};
      4'h4: exp_w = (k % 2) ? 14'h2aaa : 14'h1555;
      4'h7: exp_w = (k % 2) ? 14'h3fff : 14'h0000;
      default: exp_w = (m[7] && k > 3) ? 14'h0000 : u[15:2];
    endcase
  endfunction
  task automatic go(input logic [7:0] m, input logic ob, input int n);
    wr(12'h550, 8'h00);
    offset_binary = ob;
    wr(12'h550, m);
    run(n);
    for (int k = 0; k < n; k++) begin
      chk(32'(rx.q[k].conv.a), 32'(exp_w(m, k, ob)), "channel a");
      chk(32'(rx.q[k].conv.b), 32'(exp_w(m, k, ob)), "channel b");
    end
    $display("test mode %h done", m);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------
  // Main sequence
  // ---------
  initial begin
    logic [11:0] addr [7];
    logic [15:0] e;
    addr = '{12'h550, 12'h551, 12'h558, 12'h327, 12'h347, 12'h367, 12'h387};
    void'($urandom(32'hdb59eefb));
    {rstn, reg_wr, ddc_mode, offset_binary, stall, in_valid} = 6'h00;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    in_frame = '0;
    repeat (10) @(posedge clk);
    #1;
    chk(32'(test_active), 32'h0, "active in reset");
    rstn = 1'b1;
    foreach (addr[i]) rd(addr[i], 8'h00);
    for (int i = 0; i < 8; i++) begin
      ub[i] = 8'($urandom);
      wr(12'h551 + 12'(i), ub[i]);
      rd(12'h551 + 12'(i), ub[i]);
    end
    wr(12'h123, 8'h5a);
    rd(12'h123, 8'h00);
    $display("test registers done");
    stall = 1'b1;
    run(12);
    for (int k = 0; k < 12; k++) begin
      chk(32'(rx.q[k].conv), 32'(tx[k].conv), "passthrough");
      chk(rx.q[k].ddc[0], tx[k].ddc[0], "ddc passthrough");
    end
    chk(32'(full_seen > 0), 32'h1, "buffer never refused");
    $display("test off done");
    for (int m = 1; m < 4; m++) begin
      go(8'(m), 1'b0, 4);
      go(8'(m), 1'b1, 4);
    end
    go(8'h04, 1'b1, 7);
    go(8'h07, 1'b1, 7);
    go(8'h08, 1'b0, 10);
    go(8'h88, 1'b0, 8);
    wr(12'h550, 8'h0f);
    run(20);
    for (int k = 1; k < 20; k++)
      chk(32'(rx.q[k].conv.a), 32'(rx.q[k-1].conv.a + 14'h0001), "ramp");
    $display("test ramp done");
    for (int m = 5; m < 7; m++) begin
      wr(12'h550, 8'(m) | 8'h10);
      wr(12'h550, 8'(m));
      run(6);
      pn = rx.q;
      wr(12'h550, 8'(m) | 8'h20);
      wr(12'h550, 8'(m));
      run(6);
      chk(32'(pn[0].conv.a != pn[1].conv.a), 32'h1, "sequence stuck");
      for (int k = 0; k < 6; k++) begin
        chk(32'(rx.q[k].conv.a), 32'(pn[k].conv.a), "reseed");
        chk(32'(rx.q[k].conv.b), 32'(pn[k].conv.a), "channel b");
      end
    end
    $display("test pseudorandom done");
    ddc_mode = 1'b1;
    wr(12'h327, 8'h05);
    wr(12'h347, 8'h00);
    wr(12'h387, 8'h05);
    wr(12'h550, 8'h00);
    wr(12'h550, 8'h04);
    run(4);
    for (int k = 0; k < 4; k++) begin
      e = {exp_w(8'h04, k, 1'b0), 2'b00};
      chk(32'(rx.q[k].ddc[0].i), 32'(e), "ddc i");
      chk(32'(rx.q[k].ddc[0].q), 32'(e), "ddc q");
      chk(rx.q[k].ddc[1], tx[k].ddc[1], "ddc disabled");
      chk(32'(rx.q[k].ddc[3].i), 32'(e), "fourth i");
      chk(32'(rx.q[k].ddc[3].q), 32'(tx[k].ddc[3].q), "fourth q");
    end
    $display("test downconverter done");
    finish_test();
  end
endmodule
